// ===== adcsh_params.svh
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADCSH_PARAMS_SVH
`define ADCSH_PARAMS_SVH

`define ADCSH_OFF_CTRL        12'h000
`define ADCSH_OFF_SHMODE      12'h004
`define ADCSH_OFF_SSTATE      12'h008
`define ADCSH_OFF_CLKDIV      12'h00C
`define ADCSH_OFF_RESULT      12'h010
`define ADCSH_OFF_REQFLAG     12'h014
`define ADCSH_OFF_IRQEN       12'h018
`define ADCSH_OFF_STATUS      12'h01C
`define ADCSH_OFF_MASK        12'h020

`define ADCSH_CTRL_START_BIT  0
`define ADCSH_CTRL_IE_BIT     1
`define ADCSH_CTRL_RES_LSB    2
`define ADCSH_CTRL_RES_MSB    3
`define ADCSH_CTRL_BUSY_BIT   4
`define ADCSH_SHMODE_CONT_BIT 0

`define ADCSH_SSTATE_RST      8'h0B
`define ADCSH_CLKDIV_RST      8'h00
`define ADCSH_RES_12          2'h0
`define ADCSH_RES_10          2'h1
`define ADCSH_RES_8           2'h2

`define ADCSH_CONV_CLK_8      5'h09
`define ADCSH_CONV_CLK_10     5'h0B
`define ADCSH_CONV_CLK_12     5'h0D
`define ADCSH_SSTATE_MIN      8'h01

`define ADCSH_ST_DONE_BIT     0
`endif

// ===== adcsh_pkg.sv
// Types shared by the converter control block
package adcsh_pkg;
   typedef enum logic [1:0] {
      ADCSH_IDLE   = 2'b00,
      ADCSH_SAMPLE = 2'b01,
      ADCSH_CONV   = 2'b10,
      ADCSH_STORE  = 2'b11
   } adcsh_state_e;

   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic        valid;
   } adcsh_addr_s;

   typedef struct packed {
      logic       cont_sample;
      logic [1:0] res_mode;
      logic       start_req;
   } adcsh_analog_s;
endpackage

// ===== adcsh_top.sv
// Converter control: sample-hold mode, timing, end-of-conversion request flag, AHB-Lite slave
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`include "adcsh_params.svh"

// Contract
// - Bit 0 of the sample-hold mode register turns continuous sampling off (0) or on (1).
// - With the scan-end interrupt enable set, the end-of-conversion request reaches the flag.
// - A conversion end sets the request flag only while the scan-end interrupt enable is set, and O_IRQ_REQ stays low while it is clear.
// - Writing 0 to the request flag register clears it, which software does before a new start.
// - The request flag reads 1 only after the result has been written into the result register.
// - Conversion time is shortest in 8-bit mode, longer in 10-bit and longest in 12-bit mode.
// - The sampling-state register sets how many converter clock states form one sample.
// - The converter clock is a post-scaled version of the peripheral clock.
// - Sampling lasts the state count times one converter clock period, and the count resets to 0Bh.
module adcsh_top
   import adcsh_pkg::*;
#(
   parameter int DATA_W = 12
) (
   input  wire logic              I_MCLK,       // Peripheral clock, 20 MHz
   input  wire logic              I_SYS_RST,    // Synchronous reset, active high
   input  wire logic              I_HSEL,       // AHB slave select
   input  wire logic [31:0]       I_HADDR,      // AHB address
   input  wire logic [1:0]        I_HTRANS,     // AHB transfer type
   input  wire logic              I_HWRITE,     // AHB write
   input  wire logic [2:0]        I_HSIZE,      // AHB size
   input  wire logic [31:0]       I_HWDATA,     // AHB write data
   input  wire logic              I_HREADY,     // AHB bus ready
   input  wire logic [DATA_W-1:0] I_ADC_DATA,   // Analog core result, same clock
   output logic [31:0]            O_HRDATA,     // AHB read data
   output logic                   O_HREADYOUT,  // AHB slave ready
   output logic                   O_HRESP,      // AHB response, always OKAY
   output logic                   O_CONT_SAMPLE,// Continuous sampling to sample-hold
   output logic                   O_SAMPLE,     // Sample-hold tracking window
   output logic                   O_CONV_CLK_EN,// Converter clock enable pulse
   output logic                   O_IRQ_REQ,    // Request to interrupt controller
   output logic                   O_IRQ         // Level interrupt
);

   initial begin
      if (DATA_W < 8 || DATA_W > 32) begin
         $error("DATA_W out of range");
      end
   end

   adcsh_addr_s   aph_reg;
   adcsh_state_e  state_reg;
   logic          ie_reg;
   logic [1:0]    res_reg;
   logic          shmode_reg;
   logic [7:0]    sstate_reg;
   logic [7:0]    clkdiv_reg;
   logic [7:0]    div_cnt_reg;
   logic          tick_reg;
   logic [7:0]    cnt_reg;
   logic [DATA_W-1:0] result_reg;
   logic          reqflag_reg;
   logic          irqen_reg;
   logic          status_reg;
   logic          mask_reg;
   logic          done_pulse_reg;
   logic [31:0]   rdata_next;
   logic          wr_en;
   logic          start_wr;
   logic [4:0]    conv_len;
   logic [11:0]   wr_off;

   // Address phase capture
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         aph_reg <= '0;
      end else if (I_HREADY) begin
         aph_reg.addr  <= I_HADDR;
         aph_reg.write <= I_HWRITE;
         aph_reg.valid <= I_HSEL & I_HTRANS[1];
      end
   end

   assign wr_en    = aph_reg.valid & aph_reg.write;
   assign wr_off   = aph_reg.addr[11:0];
   assign start_wr = wr_en && (wr_off == `ADCSH_OFF_CTRL)
                     && I_HWDATA[`ADCSH_CTRL_START_BIT];

   // Control register fields
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         ie_reg  <= 1'b0;
         res_reg <= `ADCSH_RES_12;
      end else if (wr_en && wr_off == `ADCSH_OFF_CTRL) begin
         ie_reg  <= I_HWDATA[`ADCSH_CTRL_IE_BIT];
         res_reg <= I_HWDATA[`ADCSH_CTRL_RES_MSB:`ADCSH_CTRL_RES_LSB];
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         shmode_reg <= 1'b0;
      end else if (wr_en && wr_off == `ADCSH_OFF_SHMODE) begin
         shmode_reg <= I_HWDATA[`ADCSH_SHMODE_CONT_BIT];
      end
   end

   // state count, zero would give no window so floor at one
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         sstate_reg <= `ADCSH_SSTATE_RST;
      end else if (wr_en && wr_off == `ADCSH_OFF_SSTATE) begin
         sstate_reg <= (I_HWDATA[7:0] < `ADCSH_SSTATE_MIN) ? `ADCSH_SSTATE_MIN
                                                            : I_HWDATA[7:0];
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         clkdiv_reg <= `ADCSH_CLKDIV_RST;
      end else if (wr_en && wr_off == `ADCSH_OFF_CLKDIV) begin
         clkdiv_reg <= I_HWDATA[7:0];
      end
   end

   // converter clock is a pulse every clkdiv+1 peripheral clocks
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         div_cnt_reg <= 8'h00;
         tick_reg    <= 1'b0;
      end else if (start_wr && state_reg == ADCSH_IDLE) begin
         // realign so every sampling state lasts one full converter clock period
         div_cnt_reg <= (clkdiv_reg == 8'h00) ? 8'h00 : 8'h01;
         tick_reg    <= (clkdiv_reg == 8'h00);
      end else if (div_cnt_reg >= clkdiv_reg) begin
         div_cnt_reg <= 8'h00;
         tick_reg    <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
         tick_reg    <= 1'b0;
      end
   end

   // more bits take more converter clocks
   always_comb begin
      case (res_reg)
         `ADCSH_RES_8:  conv_len = `ADCSH_CONV_CLK_8;
         `ADCSH_RES_10: conv_len = `ADCSH_CONV_CLK_10;
         default:       conv_len = `ADCSH_CONV_CLK_12;
      endcase
   end

   // Conversion sequencer
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         state_reg      <= ADCSH_IDLE;
         cnt_reg        <= 8'h00;
         result_reg     <= '0;
         done_pulse_reg <= 1'b0;
      end else begin
         done_pulse_reg <= 1'b0;
         case (state_reg)
            ADCSH_IDLE: begin
               if (start_wr) begin
                  state_reg <= ADCSH_SAMPLE;
                  cnt_reg   <= 8'h00;
               end
            end
            ADCSH_SAMPLE: begin
               // window is sstate converter clock periods
               if (tick_reg) begin
                  if (cnt_reg + 8'h01 >= sstate_reg) begin
                     state_reg <= ADCSH_CONV;
                     cnt_reg   <= 8'h00;
                  end else begin
                     cnt_reg <= cnt_reg + 8'h01;
                  end
               end
            end
            ADCSH_CONV: begin
               if (tick_reg) begin
                  if (cnt_reg + 8'h01 >= {3'b000, conv_len}) begin
                     state_reg <= ADCSH_STORE;
                  end else begin
                     cnt_reg <= cnt_reg + 8'h01;
                  end
               end
            end
            ADCSH_STORE: begin
               // result stored here, flag sets on the next edge
               result_reg     <= I_ADC_DATA;
               done_pulse_reg <= 1'b1;
               state_reg      <= ADCSH_IDLE;
            end
            default: state_reg <= ADCSH_IDLE;
         endcase
      end
   end

   // request flag, set wins over a clearing write of 0
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         reqflag_reg <= 1'b0;
      end else if (done_pulse_reg && ie_reg) begin
         reqflag_reg <= 1'b1;
      end else if (wr_en && wr_off == `ADCSH_OFF_REQFLAG && !I_HWDATA[0]) begin
         reqflag_reg <= 1'b0;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         irqen_reg <= 1'b0;
         mask_reg  <= 1'b0;
      end else if (wr_en && wr_off == `ADCSH_OFF_IRQEN) begin
         irqen_reg <= I_HWDATA[0];
      end else if (wr_en && wr_off == `ADCSH_OFF_MASK) begin
         mask_reg <= I_HWDATA[`ADCSH_ST_DONE_BIT];
      end
   end

   // Sticky done status, write one to clear, set wins
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         status_reg <= 1'b0;
      end else if (done_pulse_reg) begin
         status_reg <= 1'b1;
      end else if (wr_en && wr_off == `ADCSH_OFF_STATUS && I_HWDATA[`ADCSH_ST_DONE_BIT]) begin
         status_reg <= 1'b0;
      end
   end

   always_comb begin
      rdata_next = 32'h0000_0000;
      case (I_HADDR[11:0])
         `ADCSH_OFF_CTRL: begin
            rdata_next[`ADCSH_CTRL_IE_BIT] = ie_reg;
            rdata_next[`ADCSH_CTRL_RES_MSB:`ADCSH_CTRL_RES_LSB] = res_reg;
            rdata_next[`ADCSH_CTRL_BUSY_BIT] = (state_reg != ADCSH_IDLE);
         end
         `ADCSH_OFF_SHMODE:  rdata_next[`ADCSH_SHMODE_CONT_BIT] = shmode_reg;
         `ADCSH_OFF_SSTATE:  rdata_next[7:0] = sstate_reg;
         `ADCSH_OFF_CLKDIV:  rdata_next[7:0] = clkdiv_reg;
         `ADCSH_OFF_RESULT:  rdata_next[DATA_W-1:0] = result_reg;
         `ADCSH_OFF_REQFLAG: rdata_next[0] = reqflag_reg;
         `ADCSH_OFF_IRQEN:   rdata_next[0] = irqen_reg;
         `ADCSH_OFF_STATUS:  rdata_next[`ADCSH_ST_DONE_BIT] = status_reg;
         `ADCSH_OFF_MASK:    rdata_next[`ADCSH_ST_DONE_BIT] = mask_reg;
         default:            rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data registered at the address phase so the slave never waits
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_HRDATA <= 32'h0000_0000;
      end else if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
         O_HRDATA <= rdata_next;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_HREADYOUT   <= 1'b1;
         O_HRESP       <= 1'b0;
         O_CONT_SAMPLE <= 1'b0;
         O_SAMPLE      <= 1'b0;
         O_CONV_CLK_EN <= 1'b0;
         O_IRQ_REQ     <= 1'b0;
         O_IRQ         <= 1'b0;
      end else begin
         O_HREADYOUT   <= 1'b1;
         O_HRESP       <= 1'b0;
         O_CONT_SAMPLE <= shmode_reg;
         O_SAMPLE      <= (state_reg == ADCSH_SAMPLE);
         O_CONV_CLK_EN <= tick_reg;
         O_IRQ_REQ     <= done_pulse_reg & ie_reg;
         // interrupt from the request flag when the controller enable is set, or from the done status when its mask is set
         O_IRQ         <= (reqflag_reg & irqen_reg) | (status_reg & mask_reg);
      end
   end

endmodule

// ===== adcsh_chk_assertions.sv
// Port checker for the converter control block
`timescale 1ns/10ps
`include "adcsh_params.svh"
module adcsh_chk (
   input wire logic        I_MCLK,        // Clock
   input wire logic        I_SYS_RST,     // Reset
   input wire logic        I_HSEL,        // Select
   input wire logic [31:0] I_HADDR,       // Address
   input wire logic [1:0]  I_HTRANS,      // Type
   input wire logic        I_HWRITE,      // Write
   input wire logic [31:0] I_HWDATA,      // Data
   input wire logic        I_HREADY,      // Ready
   input wire logic [31:0] O_HRDATA,      // Read data
   input wire logic        O_HREADYOUT,   // Ready out
   input wire logic        O_HRESP,       // Response
   input wire logic        O_CONT_SAMPLE, // Mode
   input wire logic        O_SAMPLE,      // Window
   input wire logic        O_IRQ_REQ      // Request
);
   logic       wr_shm;
   logic       rd_shm;
   logic [7:0] gap;
   wire        shm_hit = I_HSEL & I_HTRANS[1] & I_HREADY & (I_HADDR[11:0] == `ADCSH_OFF_SHMODE);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);
   always_ff @(posedge I_MCLK) begin
      wr_shm <= !I_SYS_RST & shm_hit & I_HWRITE;
      rd_shm <= !I_SYS_RST & shm_hit & !I_HWRITE;
   end
   // Saturates so a long idle spell never wraps into a false short gap
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST || O_SAMPLE) begin
         gap <= 8'h00;
      end else if (gap != 8'hFF) begin
         gap <= gap + 8'h01;
      end
   end
   a_mode_follows:
   assert property (wr_shm |-> ##2 O_CONT_SAMPLE == $past(I_HWDATA[0], 2)) else $error("mode out");
   a_mode_quiet:
   assert property ($changed(O_CONT_SAMPLE) |-> $past(wr_shm) || $past(wr_shm, 2))
      else $error("mode moved");
   a_bus_okay:
   assert property (O_HREADYOUT && !O_HRESP) else $error("bus answer");
   a_rsvd_zero:
   assert property (rd_shm |-> O_HRDATA[31:1] == 31'h0) else $error("reserved bits");
   a_req_pulse:
   assert property (O_IRQ_REQ |=> !O_IRQ_REQ) else $error("request width");
   a_req_after:
   assert property (O_IRQ_REQ |-> !O_SAMPLE) else $error("request in window");
   a_conv_gap:
   assert property (O_IRQ_REQ |-> gap >= 8'h08) else $error("request early");
   a_reset_low:
   assert property ($fell(I_SYS_RST) |-> !O_CONT_SAMPLE && !O_SAMPLE) else $error("reset out");
endmodule
bind adcsh_top adcsh_chk u_chk (.I_MCLK, .I_SYS_RST, .I_HSEL, .I_HADDR, .I_HTRANS, .I_HWRITE,
   .I_HWDATA, .I_HREADY, .O_HRDATA, .O_HREADYOUT, .O_HRESP, .O_CONT_SAMPLE, .O_SAMPLE,
   .O_IRQ_REQ);

// ===== adcsh_core_model.sv
// Behavioural analog core feeding results to the converter control block
`timescale 1ns/10ps
module adcsh_core_model (
   input  wire logic        i_clk,    // Clock
   input  wire logic        i_sample, // Window
   input  wire logic [11:0] i_level,  // Level
   output logic      [11:0] o_data    // Result
);
   logic [5:0] hold = 6'h00;
   initial o_data = 12'h000;
   always_ff @(posedge i_clk) begin
      if (i_sample) begin
         hold <= 6'h3F;
         o_data <= ~i_level;
      end else if (hold != 6'h00) begin
         hold <= hold - 6'h01;
         o_data <= i_level;
      end else begin
         o_data <= ~o_data;
      end
   end
endmodule

// ===== tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`include "adcsh_params.svh"
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwr = 1'b0;
   logic [1:0]  htr = 2'h0;
   logic [31:0] hadr = 32'h0;
   logic [31:0] hwd = 32'h0;
   logic [11:0] level = 12'h5A3;
   logic [11:0] adc;
   logic [31:0] hrd;
   logic [31:0] q;
   logic        rdy, cont, samp, cke, req, irq, samp_d;
   int          err_count = 0;
   int          comparisons = 0;
   int          cnt = 0, wlen = 0, clen = 0, nreq = 0, c10, c12, n0;
   adcsh_top u_dut (.I_MCLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(hadr),
      .I_HTRANS(htr), .I_HWRITE(hwr), .I_HSIZE(3'h2), .I_HWDATA(hwd), .I_HREADY(rdy),
      .I_ADC_DATA(adc), .O_HRDATA(hrd), .O_HREADYOUT(rdy), .O_HRESP(), .O_CONT_SAMPLE(cont),
      .O_SAMPLE(samp), .O_CONV_CLK_EN(cke), .O_IRQ_REQ(req), .O_IRQ(irq));
   adcsh_core_model u_core (.i_clk(clk), .i_sample(samp), .i_level(level), .o_data(adc));
   initial begin
      forever #25 clk = ~clk;
   end
   // Window length, and cycles from window end to request
   always @(posedge clk) begin
      samp_d <= samp;
      cnt <= (samp != samp_d) ? 1 : cnt + 1;
      if (samp_d && !samp) begin
         wlen <= cnt;
      end
      if (req) begin
         clen <= cnt;
         nreq <= nreq + 1;
      end
   end
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htr <= 2'h2;
      hadr <= {20'h0, a};
      hwr <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      hsel <= 1'b0;
      htr <= 2'h0;
      hwd <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      q = hrd;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // Start, then poll the busy bit; the poll gives up after 500 reads and counts an error
   task automatic conv(input logic [1:0] r, input logic ie);
      int n;
      n = 0;
      bus(1'b1, `ADCSH_OFF_CTRL, {28'h0, r, ie, 1'b1});
      do begin
         bus(1'b0, `ADCSH_OFF_CTRL, 32'h0);
         n++;
      end while (q[4] !== 1'b0 && n < 500);
      if (n >= 500) begin
         err_count++;
         $display("BAD %0t conversion never ended", $time);
      end
      // Let the request pulse reach the bench monitors
      repeat (2) @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`ADCSH_OFF_SSTATE, 32'h0B);
      rd(`ADCSH_OFF_SHMODE, 32'h0);
      rd(`ADCSH_OFF_REQFLAG, 32'h0);
      rd(12'h040, 32'h0);
      bus(1'b1, `ADCSH_OFF_SHMODE, 32'hFFFF_FFFF);
      rd(`ADCSH_OFF_SHMODE, 32'h1);
      chk({31'h0, cont}, 32'h1);
      bus(1'b1, `ADCSH_OFF_SHMODE, 32'hFFFF_FFFE);
      rd(`ADCSH_OFF_SHMODE, 32'h0);
      chk({31'h0, cont}, 32'h0);
      bus(1'b1, `ADCSH_OFF_REQFLAG, 32'h0);
      conv(`ADCSH_RES_12, 1'b1);
      chk(wlen, 32'h0B);
      rd(`ADCSH_OFF_REQFLAG, 32'h1);
      rd(`ADCSH_OFF_RESULT, {20'h0, level});
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, `ADCSH_OFF_REQFLAG, 32'h1);
      rd(`ADCSH_OFF_REQFLAG, 32'h1);
      c12 = clen;
      level <= 12'h0C3;
      conv(`ADCSH_RES_10, 1'b1);
      rd(`ADCSH_OFF_RESULT, 32'h0C3);
      c10 = clen;
      conv(`ADCSH_RES_8, 1'b1);
      chk({31'h0, clen < c10 && c10 < c12}, 32'h1);
      bus(1'b1, `ADCSH_OFF_IRQEN, 32'h1);
      rd(`ADCSH_OFF_IRQEN, 32'h1);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, `ADCSH_OFF_IRQEN, 32'h0);
      bus(1'b1, `ADCSH_OFF_MASK, 32'h1);
      rd(`ADCSH_OFF_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, `ADCSH_OFF_STATUS, 32'h1);
      bus(1'b1, `ADCSH_OFF_REQFLAG, 32'h0);
      rd(`ADCSH_OFF_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      n0 = nreq;
      bus(1'b1, `ADCSH_OFF_SSTATE, 32'h05);
      bus(1'b1, `ADCSH_OFF_CLKDIV, 32'h01);
      conv(`ADCSH_RES_12, 1'b0);
      chk(wlen, 32'h0A);
      chk(nreq - n0, 32'h0);
      rd(`ADCSH_OFF_REQFLAG, 32'h0);
      rd(`ADCSH_OFF_SSTATE, 32'h05);
      print_verdict();
   end
endmodule
